// ==== rtl/refresh_counter.sv ====
// Purpose: counts fine-rate refreshes modulo four
// Assumes: clear and bump arriving together restart the count at one
// Notes: aligned says the count is a whole group for the rate
module refresh_counter
    import refresh_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // events
    input wire logic clear,
    input wire logic bump,
    input wire logic quadRate,
    // status
    output logic aligned,
    output logic [1:0] phase
);

    typedef struct packed
    {
        logic [1:0] phase;
    } cnt_state_t;

    cnt_state_t cur;
    cnt_state_t next_cur;

    // a bump with a clear starts a fresh group of one
    always_comb
    begin
        next_cur = cur;
        if (clear)
        begin
            next_cur.phase = bump ? 2'h1 : 2'h0;
        end
        else if (bump)
        begin
            next_cur.phase = cur.phase + 2'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign phase = cur.phase;
    // even for double rate, multiple of four for quad rate
    assign aligned = quadRate ? (cur.phase == 2'h0) : !cur.phase[0];

endmodule // refresh_counter

// ==== rtl/refresh_ctrl_cfg.svh ====
// Purpose: constants for the refresh rate controller
// Assumes: 200 MHz clock, 8Gb density timings
// Notes: times in ns, cycle counts derived from them
`ifndef REFRESH_CTRL_CFG_SVH
`define REFRESH_CTRL_CFG_SVH

`define CLK_PERIOD_NS 5
// base average refresh interval, ns
`define AVG_REFI_BASE_NS 7800
// interval for the extended range, ns
`define AVG_REFI_EXT_NS 3900
// refresh cycle times per rate, ns
`define RFC1_NS 350
`define RFC2_NS 260
`define RFC4_NS 160
// cycle counts: intervals round down, cycle times round up
`define REFI_BASE_CYC (`AVG_REFI_BASE_NS / `CLK_PERIOD_NS)
`define REFI_EXT_CYC (`AVG_REFI_EXT_NS / `CLK_PERIOD_NS)
`define RFC1_CYC ((`RFC1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RFC2_CYC ((`RFC2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RFC4_CYC ((`RFC4_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// mode-register-set wait before next command, cycles
`define MOD_WAIT_CYC 24

// software register offsets (byte addresses, registers 4 apart)
`define REG_CTRL 4'h0
`define REG_MODE 4'h4
`define REG_STATUS 4'h8
`define REG_COUNT 4'hc

// control register fields
`define CTRL_ENABLE 0
`define CTRL_TCR_EN 1
`define CTRL_EXT_TEMP 2
`define CTRL_OTF_HIGH 3

// refresh rate mode field codes
`define RATE_FIXED1 3'h0
`define RATE_FIXED2 3'h1
`define RATE_FIXED4 3'h2
`define RATE_OTF12 3'h5
`define RATE_OTF14 3'h6

// mode register numbers on the bank-group/bank pins
`define MR_RATE_SEL 3'h3
`define MR_TEMP_SEL 3'h4
`define RATE_FIELD_LSB 6
`define TCR_EN_BIT 3
`define TCR_EXT_BIT 2

`endif

// ==== rtl/refresh_ctrl_pkg.sv ====
// Purpose: types for the refresh rate controller
// Assumes: nothing
// Notes: constants live in refresh_ctrl_cfg.svh
package refresh_ctrl_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_MRS_TEMP = 3'b001,
        ST_MRS_RATE = 3'b010,
        ST_WAIT = 3'b011,
        ST_RUN = 3'b100
    } ctrl_state_t;

    // kind of refresh issued
    typedef enum logic [1:0]
    {
        KIND_1X = 2'b00,
        KIND_2X = 2'b01,
        KIND_4X = 2'b10
    } ref_kind_t;

endpackage

// ==== rtl/refresh_rate_ctrl.sv ====
// Purpose: host-side controller issuing mode-register-set and REFRESH
// Assumes: banks precharged by the surrounding controller
// Notes: 8Gb timings; refresh rate changes on unaligned counts are refused
//
// Functional notes
// - extended range refresh at extended interval
// - extended mode interval kept at 3.9us
// - program on-the-fly mode before on-the-fly refreshes
// - interval base, half, quarter per rate
// - wait cycle time of each refresh kind
// - fixed modes issue only their own kind
// - each refresh timed by its own kind
// - even double refreshes before rate change
// - even double refreshes between single refreshes
// - quad refreshes in fours before change
// - quad refreshes in fours between singles
// - same-rate fixed/otf switch is no change
// - temperature refresh only with fixed 1x
//
// The strobed register port and the address map were left to the implementer.
`include "refresh_ctrl_cfg.svh"
module refresh_rate_ctrl
    import refresh_ctrl_pkg::*;
#(
    parameter int REFI_BASE = `REFI_BASE_CYC,
    parameter int REFI_EXT = `REFI_EXT_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // software port
    input wire logic [3:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [31:0] rdData,
    // memory command bus
    output logic csN,
    output logic actN,
    output logic rasN,
    output logic casN,
    output logic weN,
    output logic [1:0] bankGroup,
    output logic [1:0] bank,
    output logic [17:0] address
);

    localparam int TW = 16;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed
    {
        ctrl_state_t state;
        logic enable;
        logic tcrEn;
        logic extTemp;
        logic otfHigh;
        logic [2:0] rateMode;
        logic [2:0] pendMode;
        logic pendValid;
        logic pendTemp;
        logic refused;
        logic [15:0] refCount;
        logic [31:0] rdData;
        logic csN;
        logic rasN;
        logic casN;
        logic weN;
        logic [1:0] bankGroup;
        logic [1:0] bank;
        logic [17:0] address;
    } ctrl_t;

    ctrl_t cur;
    ctrl_t next_cur;

    logic intervalLoad;
    logic [TW-1:0] intervalValue;
    logic intervalDone;
    logic cycleLoad;
    logic [TW-1:0] cycleValue;
    logic cycleDone;
    logic cntClear;
    logic cntBump;
    logic aligned;
    logic [1:0] phase;
    logic quadRate;
    logic fineRate;
    logic otfMode;
    logic fixedMode;
    logic useFine;
    logic issueRef;
    logic legalCode;
    logic sameRate;
    ref_kind_t kind;

    // ****************************************************************
    // mode decode
    // ****************************************************************
    // reserved codes are never programmed
    always_comb
    begin
        legalCode = 1'b0;
        case (wrData[6:4])
            `RATE_FIXED1, `RATE_FIXED2, `RATE_FIXED4,
            `RATE_OTF12, `RATE_OTF14: legalCode = 1'b1;
            default: legalCode = 1'b0;
        endcase
    end

    assign otfMode = cur.rateMode[2];
    assign quadRate = cur.rateMode[1];
    assign fineRate = (cur.rateMode != `RATE_FIXED1);
    assign fixedMode = !otfMode;
    // fixed modes issue their own kind only; otf picks by software
    assign useFine = fixedMode ? fineRate : cur.otfHigh;
    assign kind = !useFine ? KIND_1X : (quadRate ? KIND_4X : KIND_2X);
    // same fine rate across fixed and otf is no change
    assign sameRate = (cur.rateMode[1:0] == wrData[5:4]) &&
        (wrData[5:4] != 2'b00);

    assign issueRef = (cur.state == ST_RUN) && cur.enable && intervalDone &&
        cycleDone && !cur.pendValid && !cur.pendTemp;

    // interval per kind and temperature range
    always_comb
    begin
        case (kind)
            KIND_2X: intervalValue = TW'(REFI_BASE / 2);
            KIND_4X: intervalValue = TW'(REFI_BASE / 4);
            default:
                intervalValue = (cur.tcrEn && cur.extTemp) ?
                    TW'(REFI_EXT) : TW'(REFI_BASE);
        endcase
    end

    // cycle time of the kind just issued
    always_comb
    begin
        case (kind)
            KIND_2X: cycleValue = TW'(`RFC2_CYC);
            KIND_4X: cycleValue = TW'(`RFC4_CYC);
            default: cycleValue = TW'(`RFC1_CYC);
        endcase
    end

    assign intervalLoad = issueRef;
    assign cntBump = issueRef && useFine;
    // a single refresh closes a group of fine refreshes
    assign cntClear = (issueRef && !useFine) ||
        (cur.state == ST_MRS_RATE &&
        cur.pendMode[1:0] != cur.rateMode[1:0]);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        next_cur = cur;
        cycleLoad = 1'b0;
        next_cur.csN = 1'b1;
        next_cur.rasN = 1'b1;
        next_cur.casN = 1'b1;
        next_cur.weN = 1'b1;
        next_cur.rdData = 32'h0;
        // software writes
        if (wrStrobe)
        begin
            case (addr)
                `REG_CTRL:
                begin
                    next_cur.enable = wrData[`CTRL_ENABLE];
                    // single refreshes in otf only when aligned
                    if (!wrData[`CTRL_OTF_HIGH] && cur.otfHigh
                        && !aligned)
                    begin
                        next_cur.refused = 1'b1;
                    end
                    else
                    begin
                        next_cur.otfHigh = wrData[`CTRL_OTF_HIGH];
                    end
                    // temperature refresh needs fixed 1x
                    if (wrData[`CTRL_TCR_EN] &&
                        cur.pendMode != `RATE_FIXED1)
                    begin
                        next_cur.refused = 1'b1;
                    end
                    else
                    begin
                        next_cur.pendTemp = 1'b1;
                        next_cur.tcrEn = wrData[`CTRL_TCR_EN];
                        next_cur.extTemp = wrData[`CTRL_EXT_TEMP];
                    end
                end
                `REG_MODE:
                begin
                    if (!legalCode || (cur.tcrEn &&
                        wrData[6:4] != `RATE_FIXED1))
                    begin
                        next_cur.refused = 1'b1;
                    end
                    else if (fineRate && !aligned && !sameRate)
                    begin
                        next_cur.refused = 1'b1;
                    end
                    else
                    begin
                        next_cur.pendMode = wrData[6:4];
                        next_cur.pendValid = 1'b1;
                    end
                end
                `REG_STATUS: next_cur.refused = 1'b0;
                default: next_cur.refused = cur.refused;
            endcase
        end
        // software reads, data stand one cycle later
        if (rdStrobe)
        begin
            case (addr)
                `REG_CTRL: next_cur.rdData = {28'h0, cur.otfHigh,
                    cur.extTemp, cur.tcrEn, cur.enable};
                `REG_MODE: next_cur.rdData = {25'h0, cur.rateMode, 4'h0};
                `REG_STATUS: next_cur.rdData = {24'h0, cur.refused,
                    aligned, phase, 1'b0, cur.state};
                `REG_COUNT: next_cur.rdData = {16'h0, cur.refCount};
                default: next_cur.rdData = 32'h0;
            endcase
        end
        case (cur.state)
            ST_IDLE:
            begin
                if (cur.enable)
                begin
                    next_cur.state = ST_MRS_TEMP;
                end
            end
            ST_MRS_TEMP:
            begin
                // temperature config word, then rate word
                next_cur.csN = 1'b0;
                next_cur.rasN = 1'b0;
                next_cur.casN = 1'b0;
                next_cur.weN = 1'b0;
                next_cur.bankGroup = 2'(`MR_TEMP_SEL >> 2);
                next_cur.bank = 2'(`MR_TEMP_SEL);
                next_cur.address = '0;
                next_cur.address[`TCR_EN_BIT] = cur.tcrEn;
                next_cur.address[`TCR_EXT_BIT] = cur.extTemp;
                next_cur.pendTemp = 1'b0;
                next_cur.state = ST_MRS_RATE;
                cycleLoad = 1'b1;
            end
            ST_MRS_RATE:
            begin
                if (cycleDone)
                begin
                    next_cur.csN = 1'b0;
                    next_cur.rasN = 1'b0;
                    next_cur.casN = 1'b0;
                    next_cur.weN = 1'b0;
                    next_cur.bankGroup = 2'(`MR_RATE_SEL >> 2);
                    next_cur.bank = 2'(`MR_RATE_SEL);
                    next_cur.address = '0;
                    next_cur.address[`RATE_FIELD_LSB +: 3] =
                        cur.pendValid ? cur.pendMode : cur.rateMode;
                    // rate applies from programming onward
                    next_cur.rateMode = cur.pendValid ?
                        cur.pendMode : cur.rateMode;
                    next_cur.pendValid = 1'b0;
                    next_cur.state = ST_WAIT;
                    cycleLoad = 1'b1;
                end
            end
            ST_WAIT:
            begin
                if (cycleDone)
                begin
                    next_cur.state = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (!cur.enable)
                begin
                    next_cur.state = ST_IDLE;
                end
                else if ((cur.pendValid || cur.pendTemp) && cycleDone)
                begin
                    next_cur.state = ST_MRS_TEMP;
                end
                else if (issueRef)
                begin
                    // refresh: cs, ras, cas low, we high
                    next_cur.csN = 1'b0;
                    next_cur.rasN = 1'b0;
                    next_cur.casN = 1'b0;
                    next_cur.weN = 1'b1;
                    next_cur.bankGroup = {1'b0, useFine && otfMode};
                    next_cur.bank = 2'h0;
                    next_cur.address = '0;
                    next_cur.refCount = cur.refCount + 16'h1;
                    cycleLoad = 1'b1;
                end
            end
            default: next_cur.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cur <= '0;
            cur.csN <= 1'b1;
            cur.rasN <= 1'b1;
            cur.casN <= 1'b1;
            cur.weN <= 1'b1;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    // mode set waits a fixed gap; refresh waits its cycle time
    refresh_timer #(.WIDTH(TW)) cycleTimer
    (
        .clk(clk),
        .resetn(resetn),
        .load(cycleLoad),
        .loadValue(cur.state == ST_RUN ? cycleValue :
            TW'(`MOD_WAIT_CYC)),
        .done(cycleDone)
    );

    refresh_timer #(.WIDTH(TW)) intervalTimer
    (
        .clk(clk),
        .resetn(resetn),
        .load(intervalLoad),
        .loadValue(intervalValue - TW'(1)), // reload at zero adds a cycle
        .done(intervalDone)
    );

    refresh_counter fineCount
    (
        .clk(clk),
        .resetn(resetn),
        .clear(cntClear),
        .bump(cntBump),
        .quadRate(quadRate),
        .aligned(aligned),
        .phase(phase)
    );

    assign rdData = cur.rdData;
    assign csN = cur.csN;
    assign actN = 1'b1;
    assign rasN = cur.rasN;
    assign casN = cur.casN;
    assign weN = cur.weN;
    assign bankGroup = cur.bankGroup;
    assign bank = cur.bank;
    assign address = cur.address;

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_TCR_FIXED1: assert property (@(posedge clk) disable iff (!resetn)
        cur.tcrEn |-> cur.rateMode == `RATE_FIXED1)
        else $error("temperature refresh with non-1x rate");

    AST_RATE_LEGAL: assert property (@(posedge clk) disable iff (!resetn)
        cur.rateMode != 3'h3 && cur.rateMode != 3'h4 &&
        cur.rateMode != 3'h7)
        else $error("reserved rate code programmed");

    AST_REF_SHAPE: assert property (@(posedge clk) disable iff (!resetn)
        (!csN && weN) |-> (!rasN && !casN))
        else $error("refresh command malformed");

    AST_RFC_GAP: assert property (@(posedge clk) disable iff (!resetn)
        (!csN && weN) |=> (csN) [*8])
        else $error("command inside refresh cycle time");

    AST_FIXED_KIND: assert property (@(posedge clk) disable iff (!resetn)
        (!csN && weN && !otfMode) |-> bankGroup == 2'h0)
        else $error("fixed mode refresh flagged as otf");

    AST_FINE_ONE: assert property (@(posedge clk) disable iff (!resetn)
        (issueRef && !useFine && otfMode) |-> aligned)
        else $error("single refresh splits a fine group");

    AST_MODE_APPLY: assert property (@(posedge clk) disable iff (!resetn)
        (cur.state == ST_MRS_RATE && cycleDone) |=>
        cur.state == ST_WAIT)
        else $error("rate programming did not advance");

    AST_CHANGE_ALIGN: assert property (@(posedge clk) disable iff (!resetn)
        (cur.state == ST_RUN && $rose(cur.pendValid) && fineRate &&
        !$past(sameRate)) |-> $past(aligned))
        else $error("rate change with unaligned fine count");

endmodule // refresh_rate_ctrl

// ==== rtl/refresh_timer.sv ====
// Purpose: down counter loaded with a cycle count, flags expiry
// Assumes: load has priority over counting
// Notes: done is high while the count is zero
module refresh_timer
    import refresh_ctrl_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // control
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    // status
    output logic done
);

    typedef struct packed
    {
        logic [WIDTH-1:0] count;
    } timer_state_t;

    timer_state_t cur;
    timer_state_t next_cur;

    // count down to zero and hold there
    always_comb
    begin
        next_cur = cur;
        if (load)
        begin
            next_cur.count = loadValue;
        end
        else if (cur.count != '0)
        begin
            next_cur.count = cur.count - WIDTH'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign done = (cur.count == '0);

endmodule // refresh_timer

// ==== verification/dram_refresh_model.sv ====
// Purpose: memory-side model watching refresh and mode commands
// Assumes: commands registered at the rising clock edge
// Notes: rule breaks are counted in errCount, never stopped on
`include "refresh_ctrl_cfg.svh"
module dram_refresh_model
    import refresh_ctrl_pkg::*;
#(
    parameter int REFI_BASE = 320,
    parameter int REFI_EXT = 160
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // command bus
    input wire logic csN,
    input wire logic actN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [1:0] bankGroup,
    input wire logic [1:0] bank,
    input wire logic [17:0] address,
    // observed state
    output logic [2:0] rateMode,
    output logic tcrOn,
    output logic extOn,
    output logic [15:0] refCount,
    output ref_kind_t lastKind,
    output int errCount,
    output int fineCount
);
    timeunit 1ns;
    timeprecision 1ps;
    logic isRef;
    logic isMrs;
    logic [2:0] mr;
    logic [2:0] code;
    int gap;
    int grp;
    int e;
    ref_kind_t kind;
    // address bits are ignored on a refresh
    assign isRef = !csN && actN && !rasN && !casN && weN;
    assign isMrs = !csN && actN && !rasN && !casN && !weN;
    assign mr = {bankGroup[0], bank};
    assign code = address[8:6];
    assign grp = rateMode[1] ? 4 : 2;
    // on-the-fly modes take the kind from bank-group bit0
    assign kind = (rateMode[2] && !bankGroup[0]) ? KIND_1X :
        (rateMode[1] ? KIND_4X : (rateMode[0] ? KIND_2X : KIND_1X));
    function automatic int rfcOf(ref_kind_t k);
        return k == KIND_1X ? `RFC1_CYC :
            (k == KIND_2X ? `RFC2_CYC : `RFC4_CYC);
    endfunction
    // each kind is timed from its own issue
    function automatic int refiOf(ref_kind_t k);
        if (k == KIND_1X)
            return (tcrOn && extOn) ? REFI_EXT : REFI_BASE;
        return k == KIND_2X ? REFI_BASE / 2 : REFI_BASE / 4;
    endfunction
    // when cool the memory may skip refreshes inside, so all are taken
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            rateMode <= 3'h0;
            tcrOn <= 1'b0;
            extOn <= 1'b0;
            refCount <= 16'h0000;
            lastKind <= KIND_1X;
            errCount <= 0;
            fineCount <= 0;
            gap <= -1;
        end
        else
        begin
            e = errCount;
            if (gap >= 0)
                gap <= gap + 1;
            if (!csN && gap >= 0 && gap < rfcOf(lastKind))
                e++;
            if (isRef)
            begin
                if (gap > refiOf(lastKind))
                    e++;
                if (kind == KIND_1X && fineCount % grp != 0)
                    e++;
                fineCount <= (kind == KIND_1X) ? 0 : fineCount + 1;
                refCount <= refCount + 16'h0001;
                lastKind <= kind;
                gap <= 1;
            end
            if (isMrs && mr == `MR_RATE_SEL)
            begin
                // a same-rate fixed and on-the-fly swap keeps the count
                if (code[1:0] != rateMode[1:0])
                begin
                    if (fineCount % grp != 0)
                        e++;
                    fineCount <= 0;
                end
                if ((tcrOn && code != 3'h0) || code inside {3'h3, 3'h4, 3'h7})
                    e++;
                rateMode <= code;
                gap <= -1;
            end
            if (isMrs && mr == `MR_TEMP_SEL)
            begin
                if (address[`TCR_EN_BIT] && rateMode != 3'h0)
                    e++;
                tcrOn <= address[`TCR_EN_BIT];
                extOn <= address[`TCR_EXT_BIT];
                gap <= -1;
            end
            errCount <= e;
        end
    end
endmodule // dram_refresh_model

// ==== verification/tb.sv ====
// Purpose: self-checking bench for the refresh rate controller
// Assumes: short refresh intervals through the design parameters
// Notes: the memory model judges command timing and counting
`include "refresh_ctrl_cfg.svh"
module tb
    import refresh_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BASE = 320;
    localparam int EXT = 160;
    logic clk;
    logic resetn;
    logic [3:0] addr;
    logic [31:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
    logic [31:0] rdData;
    logic csN, actN, rasN, casN, weN;
    logic [1:0] bankGroup;
    logic [1:0] bank;
    logic [17:0] address;
    logic [2:0] rateMode;
    logic tcrOn;
    logic extOn;
    logic [15:0] refCount;
    ref_kind_t lastKind;
    int errCount;
    int fineCount;
    int cyc = 0;
    int failCount = 0;
    int testsRun = 0;
    refresh_rate_ctrl #(.REFI_BASE(BASE), .REFI_EXT(EXT)) refresh_rate_ctrl_i
    (
        .clk(clk), .resetn(resetn), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .csN(csN), .actN(actN), .rasN(rasN), .casN(casN), .weN(weN),
        .bankGroup(bankGroup), .bank(bank), .address(address)
    );
    dram_refresh_model #(.REFI_BASE(BASE), .REFI_EXT(EXT)) dram_refresh_model_i
    (
        .clk(clk), .resetn(resetn), .csN(csN), .actN(actN), .rasN(rasN),
        .casN(casN), .weN(weN), .bankGroup(bankGroup), .bank(bank),
        .address(address), .rateMode(rateMode), .tcrOn(tcrOn),
        .extOn(extOn), .refCount(refCount), .lastKind(lastKind),
        .errCount(errCount), .fineCount(fineCount)
    );
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // a hang is cut short well past the longest expected run
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            failCount++;
            give_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            failCount++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one idle cycle after each access keeps strobes single-driven
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        addr <= a;
        wrData <= v;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 v = rdData;
        @(posedge clk);
    endtask
    task automatic doReset();
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
    endtask
    task automatic waitRefs(input int n);
        logic [15:0] t;
        t = refCount;
        for (int i = 0; i < 4000 && refCount - t < n; i++) @(posedge clk);
    endtask
    function automatic ref_kind_t kindOf(logic [2:0] m, logic h);
        if (m[2] && !h)
            return KIND_1X;
        return m[1] ? KIND_4X : (m[0] ? KIND_2X : KIND_1X);
    endfunction
    function automatic int intervalOf(ref_kind_t k);
        return k == KIND_1X ? BASE : (k == KIND_2X ? BASE / 2 : BASE / 4);
    endfunction
    initial
    begin
        logic [31:0] d;
        logic [2:0] c;
        logic hi;
        int t0;
        resetn = 1'b0;
        addr = 4'h0;
        wrData = 32'h0;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        d = $urandom(15);
        doReset();
        // reset values; holes between registers read as zero
        for (int a = 0; a < 16; a += 2)
        begin
            rd(4'(a), d);
            check(d, a == 8 ? 32'h40 : 32'h0);
        end
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            wr(`REG_MODE, {25'h0, c, 4'h0});
            rd(`REG_STATUS, d);
            check(d[7], c inside {3'h3, 3'h4, 3'h7});
            wr(`REG_STATUS, 32'h0);
        end
        $display("test rate codes done");
        wr(`REG_MODE, 32'h0);
        wr(`REG_CTRL, 32'h2);
        wr(`REG_MODE, 32'h10);
        rd(`REG_STATUS, d);
        check(d[7], 1'b1);
        wr(`REG_STATUS, 32'h0);
        wr(`REG_MODE, 32'h0);
        wr(`REG_CTRL, 32'h7);
        t0 = cyc;
        waitRefs(4);
        check(cyc - t0 <= 80 + 5 * EXT, 1'b1);
        check({tcrOn, extOn, rateMode}, 5'h18);
        rd(`REG_COUNT, d);
        check(d[15:0], refCount);
        $display("test temperature refresh done");
        for (int i = 0; i < 5; i++)
        begin
            c = i < 3 ? 3'(i) : 3'(i + 2);
            hi = 1'($urandom);
            doReset();
            wr(`REG_MODE, {25'h0, c, 4'h0});
            wr(`REG_CTRL, {28'h0, hi, 3'h1});
            t0 = cyc;
            waitRefs(4);
            check(rateMode, c);
            check(lastKind, kindOf(c, hi));
            check(cyc - t0 <= 80 + 5 * intervalOf(kindOf(c, hi)), 1'b1);
            check(errCount, 0);
        end
        $display("test rate modes done");
        // a rate change on an odd fine count is refused, a same-rate swap not
        for (int i = 1; i < 3; i++)
        begin
            c = 3'(i);
            doReset();
            wr(`REG_MODE, {25'h0, c, 4'h0});
            wr(`REG_CTRL, 32'h9);
            waitRefs(1);
            rd(`REG_STATUS, d);
            check(d[7:6], 2'b00);
            wr(`REG_MODE, 32'h0);
            rd(`REG_STATUS, d);
            check(d[7], 1'b1);
            wr(`REG_STATUS, 32'h0);
            wr(`REG_MODE, {25'h0, c | 3'h4, 4'h0});
            for (int k = 0; k < 400 && rateMode !== (c | 3'h4); k++)
                @(posedge clk);
            check(rateMode, c | 3'h4);
            waitRefs(1);
            hi = fineCount % (2 * i) != 0;
            wr(`REG_CTRL, 32'h1);
            rd(`REG_STATUS, d);
            check(d[7], hi);
            waitRefs(2);
        end
        check(errCount, 0);
        $display("test live rate changes done");
        give_verdict();
    end
endmodule // tb
